// *** src/baseband_config_status_regs.v ***
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
`include "baseband_regs_defines.vh"

module baseband_config_status_regs
(
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire [7:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [7:0] rdata_out,
    input wire [7:0] modulation_config_reg_in,
    input wire [7:0] energy_in,
    input wire [7:0] noise_floor_first_antenna_in,
    input wire [7:0] noise_floor_second_antenna_in,
    input wire [7:0] rssi_raw_in,
    input wire first_squelch_measure_in,
    input wire [7:0] corr_peak_in,
    input wire corr_peak_valid_in,
    input wire channel_matched_filter_run_in,
    input wire [7:0] test_bus_in,
    input wire [7:0] snr_quality_in,
    input wire [6:0] gain_loop_error_in,
    input wire [7:0] rx_signal_in,
    input wire [7:0] rx_service_in,
    input wire [15:0] rx_length_in,
    output reg [7:0] scrambler_seed_out,
    output reg energy_detect_out,
    output reg carrier_detect_out,
    output reg antenna_search_out,
    output reg [7:0] rssi_out,
    output reg gain_double_out,
    output reg [5:0] preamble_lead_out,
    output reg [5:0] preamble_lag_out,
    output reg [5:0] header_lead_out,
    output reg [5:0] header_lag_out,
    output reg [5:0] data_lead_out,
    output reg [5:0] data_lag_out,
    output reg [5:0] squelch_scale_out
);

// ****************************************
// writable registers
// ****************************************
reg [7:0] scrambler_seed_long;
reg [7:0] scrambler_seed_short;
reg [7:0] energy_detect_threshold_reg;
reg [7:0] matched_filter_gain_threshold;
reg [7:0] antenna_search_threshold_reg;
reg [7:0] preamble_lead_coeff;
reg [7:0] preamble_lag_coeff;
reg [7:0] header_lead_coeff;
reg [7:0] header_lag_coeff;
reg [7:0] data_lead_coeff;
reg [7:0] data_lag_coeff;
reg [7:0] rf_attenuator_value;
reg [7:0] squelch_control;
reg [7:0] status_view_select;

// limit a coefficient field to its top code
function [5:0] clamp_coeff;
    input [7:0] value;
    begin
        if (value[5:0] > `COEFF_MAX)
            clamp_coeff = `COEFF_MAX;
        else
            clamp_coeff = value[5:0];
    end
endfunction

// saturating 8-bit add
function [7:0] sat_add;
    input [7:0] a;
    input [7:0] b;
    reg [8:0] s;
    begin
        s = {1'b0, a} + {1'b0, b};
        sat_add = s[8] ? 8'hff : s[7:0];
    end
endfunction

// ****************************************
// register writes
// ****************************************
// register write port, full byte stored
always @(posedge ref_clk_in)
begin
    if (!rst_n_in)
    begin
        scrambler_seed_long <= `REG_RESET;
        scrambler_seed_short <= `REG_RESET;
        energy_detect_threshold_reg <= `REG_RESET;
        matched_filter_gain_threshold <= `REG_RESET;
        antenna_search_threshold_reg <= `REG_RESET;
        preamble_lead_coeff <= `REG_RESET;
        preamble_lag_coeff <= `REG_RESET;
        header_lead_coeff <= `REG_RESET;
        header_lag_coeff <= `REG_RESET;
        data_lead_coeff <= `REG_RESET;
        data_lag_coeff <= `REG_RESET;
        rf_attenuator_value <= `REG_RESET;
        squelch_control <= `REG_RESET;
        status_view_select <= `REG_RESET;
    end
    else if (wr_in)
    begin
        case (addr_in)
            `OFS_SEED_LONG: scrambler_seed_long <= wdata_in;
            `OFS_SEED_SHORT: scrambler_seed_short <= wdata_in;
            `OFS_ED_THRESH: energy_detect_threshold_reg <= wdata_in;
            `OFS_MF_GAIN: matched_filter_gain_threshold <= wdata_in;
            `OFS_ANT_THRESH: antenna_search_threshold_reg <= wdata_in;
            `OFS_PRE_LEAD: preamble_lead_coeff <= wdata_in;
            `OFS_PRE_LAG: preamble_lag_coeff <= wdata_in;
            `OFS_HDR_LEAD: header_lead_coeff <= wdata_in;
            `OFS_HDR_LAG: header_lag_coeff <= wdata_in;
            `OFS_DATA_LEAD: data_lead_coeff <= wdata_in;
            `OFS_DATA_LAG: data_lag_coeff <= wdata_in;
            `OFS_RF_ATTEN: rf_attenuator_value <= wdata_in;
            `OFS_SQUELCH: squelch_control <= wdata_in;
            `OFS_VIEW_SEL: status_view_select <= wdata_in;
            default: ;
        endcase
    end
end

// ****************************************
// synchronised status inputs
// ****************************************
reg [7:0] energy_s1, energy_s2;
reg [7:0] nfa_s1, nfa_s2;
reg [7:0] nfb_s1, nfb_s2;
reg [7:0] rssi_s1, rssi_s2;
reg sq_s1, sq_s2;
reg [7:0] peak_s1, peak_s2;
reg pv_s1, pv_s2;
reg run_s1, run_s2;
reg [7:0] tb_s1, tb_s2;
reg [7:0] snr_s1, snr_s2;
reg [6:0] err_s1, err_s2;
reg [7:0] sig_s1, sig_s2;
reg [7:0] svc_s1, svc_s2;
reg [15:0] len_s1, len_s2;
reg [7:0] mod_s1, mod_s2;

// two-stage synchronisers on all status inputs
always @(posedge ref_clk_in)
begin
    if (!rst_n_in)
    begin
        {energy_s1, energy_s2, nfa_s1, nfa_s2, nfb_s1, nfb_s2} <= 48'h0;
        {rssi_s1, rssi_s2, sq_s1, sq_s2, peak_s1, peak_s2} <= 34'h0;
        {pv_s1, pv_s2, run_s1, run_s2, tb_s1, tb_s2} <= 20'h0;
        {snr_s1, snr_s2, err_s1, err_s2, sig_s1, sig_s2} <= 46'h0;
        {svc_s1, svc_s2, len_s1, len_s2, mod_s1, mod_s2} <= 64'h0;
    end
    else
    begin
        energy_s1 <= energy_in;
        energy_s2 <= energy_s1;
        nfa_s1 <= noise_floor_first_antenna_in;
        nfa_s2 <= nfa_s1;
        nfb_s1 <= noise_floor_second_antenna_in;
        nfb_s2 <= nfb_s1;
        rssi_s1 <= rssi_raw_in;
        rssi_s2 <= rssi_s1;
        sq_s1 <= first_squelch_measure_in;
        sq_s2 <= sq_s1;
        peak_s1 <= corr_peak_in;
        peak_s2 <= peak_s1;
        pv_s1 <= corr_peak_valid_in;
        pv_s2 <= pv_s1;
        run_s1 <= channel_matched_filter_run_in;
        run_s2 <= run_s1;
        tb_s1 <= test_bus_in;
        tb_s2 <= tb_s1;
        snr_s1 <= snr_quality_in;
        snr_s2 <= snr_s1;
        err_s1 <= gain_loop_error_in;
        err_s2 <= err_s1;
        sig_s1 <= rx_signal_in;
        sig_s2 <= sig_s1;
        svc_s1 <= rx_service_in;
        svc_s2 <= svc_s1;
        len_s1 <= rx_length_in;
        len_s2 <= len_s1;
        mod_s1 <= modulation_config_reg_in;
        mod_s2 <= mod_s1;
    end
end

// ****************************************
// detection logic
// ****************************************
// usable range is 7 bits
wire [7:0] energy_detect_threshold = {1'b0, energy_detect_threshold_reg[6:0]};
wire energy_detect_mode_sel = energy_detect_threshold_reg[`ED_MODE_BIT];
wire [6:0] antenna_search_threshold = antenna_search_threshold_reg[6:0];
wire [5:0] rf_attenuator_pad = rf_attenuator_value[5:0];
reg [7:0] ed_level;
reg [7:0] ant_level;
reg [7:0] next_rssi;
reg next_ed;

// threshold and signal strength arithmetic
always @*
begin
    ed_level = energy_detect_mode_sel ? energy_detect_threshold :
        sat_add(nfa_s2, energy_detect_threshold);
    ant_level = antenna_search_threshold_reg[`ANT_MODE_BIT] ?
        {1'b0, antenna_search_threshold} : sat_add(nfa_s2, {1'b0, antenna_search_threshold});
    next_rssi = sat_add(rssi_s2, {2'b00, rf_attenuator_pad});
    next_ed = energy_s2 > ed_level;
end

// ****************************************
// gain doubling
// ****************************************
reg [3:0] peak_cnt;
reg [10:0] peak_sum;

// accumulate peaks while matched filter runs
always @(posedge ref_clk_in)
begin
    if (!rst_n_in)
    begin
        peak_cnt <= 4'h0;
        peak_sum <= 11'h000;
        gain_double_out <= 1'b0;
    end
    else if (!run_s2)
    begin
        peak_cnt <= 4'h0;
        peak_sum <= 11'h000;
        gain_double_out <= 1'b0;
    end
    else if (pv_s2 && peak_cnt != `PEAK_COUNT)
    begin
        peak_sum <= peak_sum + {3'b000, peak_s2};
        peak_cnt <= peak_cnt + 4'h1;
    end
    else if (peak_cnt == `PEAK_COUNT)
    begin
        // sum of 8 peaks versus threshold
        gain_double_out <= (matched_filter_gain_threshold != 8'h00) &&
            (peak_sum < {3'b000, matched_filter_gain_threshold});
    end
end

// ****************************************
// registered control outputs
// ****************************************
// drive outputs from flops
always @(posedge ref_clk_in)
begin
    if (!rst_n_in)
    begin
        scrambler_seed_out <= 8'h00;
        energy_detect_out <= 1'b0;
        carrier_detect_out <= 1'b0;
        antenna_search_out <= 1'b0;
        rssi_out <= 8'h00;
        preamble_lead_out <= 6'h00;
        preamble_lag_out <= 6'h00;
        header_lead_out <= 6'h00;
        header_lag_out <= 6'h00;
        data_lead_out <= 6'h00;
        data_lag_out <= 6'h00;
        squelch_scale_out <= 6'h00;
    end
    else
    begin
        scrambler_seed_out <= {1'b0, (mod_s2[`MOD_SEED_SEL_BIT] ?
            scrambler_seed_short[6:0] : scrambler_seed_long[6:0])};
        energy_detect_out <= next_ed;
        // squelch alone or with energy detect
        carrier_detect_out <= squelch_control[`SQ_CRIT_BIT] ? (next_ed & sq_s2) : sq_s2;
        antenna_search_out <= next_rssi < ant_level;
        rssi_out <= next_rssi;
        preamble_lead_out <= clamp_coeff(preamble_lead_coeff);
        preamble_lag_out <= clamp_coeff(preamble_lag_coeff);
        header_lead_out <= clamp_coeff(header_lead_coeff);
        header_lag_out <= clamp_coeff(header_lag_coeff);
        data_lead_out <= clamp_coeff(data_lead_coeff);
        data_lag_out <= clamp_coeff(data_lag_coeff);
        // 3.3 fixed point scale passed on
        squelch_scale_out <= squelch_control[5:0];
    end
end

// ****************************************
// read port
// ****************************************
wire view_a = status_view_select[`VIEW_SEL_BIT];
reg [7:0] next_rdata;

// read mux, views per status register except the test bus
always @*
begin
    next_rdata = 8'h00;
    case (addr_in)
        `OFS_SEED_LONG: next_rdata = scrambler_seed_long;
        `OFS_SEED_SHORT: next_rdata = scrambler_seed_short;
        `OFS_ED_THRESH: next_rdata = energy_detect_threshold_reg;
        `OFS_MF_GAIN: next_rdata = matched_filter_gain_threshold;
        `OFS_ANT_THRESH: next_rdata = antenna_search_threshold_reg;
        `OFS_PRE_LEAD: next_rdata = preamble_lead_coeff;
        `OFS_PRE_LAG: next_rdata = preamble_lag_coeff;
        `OFS_HDR_LEAD: next_rdata = header_lead_coeff;
        `OFS_HDR_LAG: next_rdata = header_lag_coeff;
        `OFS_DATA_LEAD: next_rdata = data_lead_coeff;
        `OFS_DATA_LAG: next_rdata = data_lag_coeff;
        `OFS_RF_ATTEN: next_rdata = rf_attenuator_value;
        `OFS_SQUELCH: next_rdata = squelch_control;
        `OFS_VIEW_SEL: next_rdata = status_view_select;
        `OFS_TEST_BUS: next_rdata = tb_s2;
        `OFS_SIG_QUAL: next_rdata = view_a ? nfa_s2 : snr_s2;
        `OFS_RX_SIGNAL: next_rdata = view_a ? nfb_s2 : sig_s2;
        `OFS_RX_SERVICE: next_rdata = view_a ? {1'b0, err_s2} : svc_s2;
        `OFS_RX_LEN_LO: next_rdata = view_a ? 8'h00 : len_s2[7:0];
        `OFS_RX_LEN_HI: next_rdata = view_a ? 8'h00 : len_s2[15:8];
        default: next_rdata = 8'h00;
    endcase
end

// read data one cycle after strobe, zero otherwise
always @(posedge ref_clk_in)
begin
    if (!rst_n_in)
        rdata_out <= 8'h00;
    else if (rd_in)
        rdata_out <= next_rdata;
    else
        rdata_out <= 8'h00;
end

endmodule // baseband_config_status_regs

// *** src/baseband_regs_defines.vh ***
`ifndef BASEBAND_REGS_DEFINES_VH
`define BASEBAND_REGS_DEFINES_VH
// ****************************************
// register offsets
// ****************************************
`define OFS_SEED_LONG 8'h48
`define OFS_SEED_SHORT 8'h4a
`define OFS_ED_THRESH 8'h4c
`define OFS_MF_GAIN 8'h4e
`define OFS_ANT_THRESH 8'h50
`define OFS_PRE_LEAD 8'h52
`define OFS_PRE_LAG 8'h54
`define OFS_HDR_LEAD 8'h56
`define OFS_HDR_LAG 8'h58
`define OFS_DATA_LEAD 8'h5a
`define OFS_DATA_LAG 8'h5c
`define OFS_RF_ATTEN 8'h5e
`define OFS_SQUELCH 8'h60
`define OFS_VIEW_SEL 8'h62
`define OFS_TEST_BUS 8'h64
`define OFS_SIG_QUAL 8'h66
`define OFS_RX_SIGNAL 8'h68
`define OFS_RX_SERVICE 8'h6a
`define OFS_RX_LEN_LO 8'h6c
`define OFS_RX_LEN_HI 8'h6e
// ****************************************
// field positions and values
// ****************************************
`define MOD_SEED_SEL_BIT 3
`define ED_MODE_BIT 7
`define ANT_MODE_BIT 7
`define SQ_CRIT_BIT 6
`define VIEW_SEL_BIT 7
`define REG_RESET 8'h00
`define PEAK_COUNT 4'h8
`define COEFF_MAX 6'h20
`endif

// *** test/baseband_regs_checker_assertions.sv ***
`timescale 1ns/100ps
module baseband_regs_checker
(
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire [7:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire [7:0] rdata_out,
    input wire [7:0] test_bus_in,
    input wire [7:0] snr_quality_in,
    input wire [7:0] noise_floor_first_antenna_in,
    input wire [6:0] gain_loop_error_in,
    input wire [7:0] rx_service_in,
    input wire [15:0] rx_length_in,
    input wire channel_matched_filter_run_in,
    input wire [7:0] scrambler_seed_out,
    input wire gain_double_out
);
    // ****************************************
    // shadow of the writable registers
    // ****************************************
    logic [7:0] shadow [0:127];
    logic [7:0] exp_q;
    wire rw_hit = addr_in >= 8'h48 && addr_in <= 8'h62 && !addr_in[0];
    wire ro_hit = addr_in >= 8'h64 && addr_in <= 8'h6e && !addr_in[0];
    wire view_a = shadow[7'h62][7];
    wire [7:0] mf_thr = shadow[7'h4e];
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    // track writes and the value a read should return
    always @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
            for (int i = 0; i < 128; i++) shadow[i] <= 8'h00;
        else if (wr_in && rw_hit)
            shadow[addr_in[6:0]] <= wdata_in;
        exp_q <= rw_hit ? shadow[addr_in[6:0]] : 8'h00;
    end
    a_reg_readback: assert property (rd_in && !ro_hit |=> rdata_out == exp_q)
        else $error("register read back wrong");
    a_test_bus_read: assert property (rd_in && addr_in == 8'h64
        |=> rdata_out == $past(test_bus_in, 3)) else $error("test bus read wrong");
    a_quality_view: assert property (rd_in && addr_in == 8'h66
        |=> rdata_out == (view_a ? $past(noise_floor_first_antenna_in, 3)
        : $past(snr_quality_in, 3))) else $error("quality read wrong");
    a_service_view: assert property (rd_in && addr_in == 8'h6a
        |=> rdata_out == (view_a ? {1'b0, $past(gain_loop_error_in, 3)}
        : $past(rx_service_in, 3))) else $error("service read wrong");
    a_len_view_a: assert property (rd_in && addr_in == 8'h6c && view_a
        |=> rdata_out == 8'h00) else $error("length view a not zero");
    a_len_view_b: assert property (rd_in && addr_in == 8'h6c && !view_a
        |=> {8'h00, rdata_out} == ($past(rx_length_in, 3) & 16'h00ff))
        else $error("length low byte wrong");
    a_gain_needs_run: assert property (gain_double_out
        |-> $past(channel_matched_filter_run_in, 4)) else $error("gain up without filter");
    a_gain_zero_off: assert property ($rose(gain_double_out) |-> $past(mf_thr) != 8'h00)
        else $error("gain doubled with zero threshold");
    a_seed_reserved_clear: assert property (scrambler_seed_out[7] == 1'b0)
        else $error("reserved seed bit reached the scrambler");
endmodule // baseband_regs_checker
bind baseband_config_status_regs baseband_regs_checker chk_i (.*);

// *** test/test_baseband_config_status_regs.sv ***
`timescale 1ns/100ps
module test_baseband_config_status_regs;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, energy_in = 8'h00, rssi_raw_in = 8'h00;
    logic wr_in = 1'b0, rd_in = 1'b0, first_squelch_measure_in = 1'b0, corr_peak_valid_in = 1'b0;
    logic channel_matched_filter_run_in = 1'b0;
    logic [7:0] modulation_config_reg_in = 8'h00, corr_peak_in = 8'h00, test_bus_in = 8'h00;
    logic [7:0] noise_floor_first_antenna_in = 8'h00, noise_floor_second_antenna_in = 8'h00;
    logic [7:0] snr_quality_in = 8'h00, rx_signal_in = 8'h00, rx_service_in = 8'h00;
    logic [6:0] gain_loop_error_in = 7'h00;
    logic [15:0] rx_length_in = 16'h0000;
    logic [7:0] rdata_out, scrambler_seed_out, rssi_out;
    logic energy_detect_out, carrier_detect_out, antenna_search_out, gain_double_out;
    logic [5:0] preamble_lead_out, preamble_lag_out, header_lead_out, header_lag_out;
    logic [5:0] data_lead_out, data_lag_out, squelch_scale_out;
    int n_mismatch = 0;
    int n_tests = 0;
    int seed = 58220;
    logic rd_seen = 1'b0;
    logic [7:0] expect_q [$];
    logic [7:0] mem [0:127];
    baseband_config_status_regs dut (.*);
    // 100 MHz clock
    initial forever #5 ref_clk_in = ~ref_clk_in;
    // ****************************************
    // bus tasks and checks
    // ****************************************
    task automatic chk(input [7:0] got, input [7:0] want);
        n_tests++;
        if (got !== want)
        begin
            n_mismatch++;
            $display("FAIL %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic wr(input [7:0] a, input [7:0] d);
        addr_in <= a;
        wdata_in <= d;
        rd_in <= 1'b0;
        wr_in <= 1'b1;
        @(posedge ref_clk_in);
    endtask
    task automatic rd(input [7:0] a, input [7:0] want);
        addr_in <= a;
        wr_in <= 1'b0;
        rd_in <= 1'b1;
        expect_q.push_back(want);
        @(posedge ref_clk_in);
    endtask
    task automatic idle(input int n);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        repeat (n) @(posedge ref_clk_in);
    endtask
    task automatic poke(input [7:0] a, input [7:0] d);
        wr(a, d);
        idle(5);
    endtask
    task automatic ed_case(input [7:0] thr, input [7:0] en, input logic want);
        energy_in <= en;
        poke(8'h4c, thr);
        chk(energy_detect_out, {7'h00, want});
    endtask
    task automatic gain_case(input [7:0] thr, input logic want);
        poke(8'h4e, thr);
        channel_matched_filter_run_in <= 1'b1;
        idle(4);
        corr_peak_in <= 8'h01;
        corr_peak_valid_in <= 1'b1;
        repeat (8) @(posedge ref_clk_in);
        corr_peak_valid_in <= 1'b0;
        idle(6);
        chk(gain_double_out, {7'h00, want});
        channel_matched_filter_run_in <= 1'b0;
        idle(5);
        chk(gain_double_out, 8'h00);
    endtask
    function automatic [5:0] coeff(input int i);
        case (i)
            0: coeff = preamble_lead_out;
            1: coeff = preamble_lag_out;
            2: coeff = header_lead_out;
            3: coeff = header_lag_out;
            4: coeff = data_lead_out;
            default: coeff = data_lag_out;
        endcase
    endfunction
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // scoreboard: read data is compared the cycle after each read strobe
    always @(posedge ref_clk_in)
    begin
        if (rd_seen)
            chk(rdata_out, expect_q.pop_front());
        rd_seen <= rd_in;
    end
    // watchdog against a hung run
    initial
    begin
        repeat (20000) @(posedge ref_clk_in);
        n_mismatch++;
        wrap_up;
    end
    // ****************************************
    // stimulus
    // ****************************************
    initial
    begin
        repeat (12) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        @(posedge ref_clk_in);
        // reset value, store and read back
        for (int a = 8'h48; a <= 8'h62; a += 2)
            rd(a[7:0], 8'h00);
        for (int a = 8'h48; a <= 8'h62; a += 2)
        begin
            mem[a] = 8'($random(seed));
            wr(a[7:0], mem[a]);
        end
        for (int a = 8'h48; a <= 8'h62; a += 2)
            rd(a[7:0], mem[a]);
        idle(1);
        $display("readback done");
        // both views, writes to read-only ignored
        test_bus_in <= 8'($random(seed));
        snr_quality_in <= 8'($random(seed));
        noise_floor_first_antenna_in <= 8'($random(seed));
        noise_floor_second_antenna_in <= 8'($random(seed));
        rx_signal_in <= 8'($random(seed));
        rx_service_in <= 8'($random(seed));
        gain_loop_error_in <= 7'($random(seed));
        rx_length_in <= 16'($random(seed));
        idle(5);
        for (int a = 8'h64; a <= 8'h6e; a += 2)
            wr(a[7:0], 8'hff);
        rd(8'h62, mem[8'h62]);
        for (int v = 0; v < 2; v++)
        begin
            wr(8'h62, {v[0], 7'h00});
            rd(8'h64, test_bus_in);
            rd(8'h66, v ? noise_floor_first_antenna_in : snr_quality_in);
            rd(8'h68, v ? noise_floor_second_antenna_in : rx_signal_in);
            rd(8'h6a, v ? {1'b0, gain_loop_error_in} : rx_service_in);
            rd(8'h6c, v ? 8'h00 : rx_length_in[7:0]);
            rd(8'h6e, v ? 8'h00 : rx_length_in[15:8]);
        end
        rd(8'h49, 8'h00);
        rd(8'h70, 8'h00);
        idle(1);
        $display("views done");
        // seed picked by modulation bit 3
        modulation_config_reg_in <= 8'hf7;
        wr(8'h48, 8'hda);
        poke(8'h4a, 8'h3c);
        chk(scrambler_seed_out, 8'h5a);
        modulation_config_reg_in <= 8'h08;
        idle(5);
        chk(scrambler_seed_out, 8'h3c);
        noise_floor_first_antenna_in <= 8'h30;
        first_squelch_measure_in <= 1'b1;
        ed_case(8'ha0, 8'h21, 1'b1);
        ed_case(8'ha0, 8'h20, 1'b0);
        ed_case(8'h10, 8'h41, 1'b1);
        ed_case(8'h7f, 8'hb0, 1'b1);
        ed_case(8'hff, 8'h7f, 1'b0);
        poke(8'h60, 8'h2d);
        chk(carrier_detect_out, 8'h01);
        chk(squelch_scale_out, 8'h2d);
        poke(8'h60, 8'hff);
        chk(carrier_detect_out, 8'h00);
        chk(squelch_scale_out, 8'h3f);
        energy_in <= 8'h80;
        idle(5);
        chk(carrier_detect_out, 8'h01);
        $display("detect done");
        noise_floor_first_antenna_in <= 8'h20;
        rssi_raw_in <= 8'h20;
        poke(8'h5e, 8'hc5);
        chk(rssi_out, 8'h25);
        poke(8'h50, 8'ha6);
        chk(antenna_search_out, 8'h01);
        poke(8'h50, 8'ha5);
        chk(antenna_search_out, 8'h00);
        poke(8'h50, 8'h06);
        chk(antenna_search_out, 8'h01);
        rssi_raw_in <= 8'hfe;
        idle(5);
        chk(rssi_out, 8'hff);
        for (int i = 0; i < 6; i++)
        begin
            poke(8'h52 + 8'(2 * i), 8'hff);
            chk({2'b00, coeff(i)}, 8'h20);
            rd(8'h52 + 8'(2 * i), 8'hff);
            poke(8'h52 + 8'(2 * i), 8'h1f);
            chk({2'b00, coeff(i)}, 8'h1f);
        end
        $display("antenna and coefficients done");
        gain_case(8'h09, 1'b1);
        gain_case(8'h08, 1'b0);
        gain_case(8'h00, 1'b0);
        $display("gain done");
        wrap_up;
    end
endmodule // test_baseband_config_status_regs
